// ==== hdl/csms_regs.sv ====
// socket interrupt-enable, event flag and live status register logic
`timescale 1ns/100ps
`default_nettype none
module csms_regs (
    // clock and reset
    input  wire  logic        clock,
    input  wire  logic        rst,
    // register port
    input  wire  logic [7:0]  reg_addr,
    input  wire  logic        reg_wr,
    input  wire  logic        reg_rd,
    input  wire  logic [31:0] reg_wdata,
    output logic       [31:0] reg_rdata,
    // socket pins, asynchronous
    input  wire  logic        card_detect_pin_one,
    input  wire  logic        card_detect_pin_two,
    input  wire  logic        card_status_change_pin,
    input  wire  logic        card_ready_pin,
    // socket logic on this clock
    input  wire  logic        socket_powered,
    input  wire  logic        card_is_cardbus,
    input  wire  logic        interrogation_busy,
    input  wire  logic        insertion_done,
    input  wire  logic [2:0]  probed_card_volt,
    // interrupt
    output logic              status_change_interrupt
);
    typedef struct packed {
        logic [3:0]  mask;       // interrupt enables
        logic [3:0]  events;     // sticky change flags
        logic [1:0]  cd_meta;    // detect pins, first stage
        logic [1:0]  cd_sync;    // detect pins, second stage
        logic        cst_meta;   // status-change pin, first stage
        logic        cst_sync;
        logic        rdy_meta;   // ready pin, first stage
        logic        rdy_sync;
        logic [1:0]  cd_stat;    // detect levels shown to software
        logic        cst_stat;
        logic        pwr_stat;
        logic        rdy_stat;
        logic [2:0]  card_volt;  // yy, xx, low volt support of card
        logic        video;      // video-port support
        logic [1:0]  settle;     // post-reset settle count
        logic [31:0] rdata;      // read data
    } csms_state_type;

    csms_state_type s_reg;       // registered state
    csms_state_type s_next;      // next state
    logic [31:0]    status_word; // live status image
    logic           primed;      // synchronisers hold real levels
    logic           wr_force;    // write to force register
    logic [3:0]     ev_set;      // flag set terms
    logic [3:0]     ev_clr;      // flag clear terms
    logic [3:0]     irq_en;      // per-flag enable

    // live status image, fixed fields are constants
    always_comb begin
        status_word = 32'h0000_0000;                         // R12
        status_word[31:28] = csms_pkg::SOCKET_SUPPLY;        // R9 R10 R14
        status_word[csms_pkg::FLD_VIDEO] = s_reg.video;      // R11
        status_word[csms_pkg::FLD_VOLT_HI:csms_pkg::FLD_VOLT_LO] = s_reg.card_volt; // R13
        status_word[csms_pkg::FLD_READY] = s_reg.rdy_stat;
        status_word[csms_pkg::FLD_POWER] = s_reg.pwr_stat;
        status_word[csms_pkg::FLD_CD_HI:csms_pkg::FLD_CD_LO] = s_reg.cd_stat; // R17
        status_word[csms_pkg::FLD_CSTS] = s_reg.cst_stat;
    end

    // next-state logic
    always_comb begin
        s_next   = s_reg;
        primed   = (s_reg.settle == csms_pkg::SETTLE_DONE);
        wr_force = reg_wr && (reg_addr == csms_pkg::OFS_FORCE);
        // two-flop synchronisers; the first stage feeds only the second
        s_next.cd_meta  = {card_detect_pin_two, card_detect_pin_one};
        s_next.cd_sync  = s_reg.cd_meta;
        s_next.cst_meta = card_status_change_pin;
        s_next.cst_sync = s_reg.cst_meta;
        s_next.rdy_meta = card_ready_pin;
        s_next.rdy_sync = s_reg.rdy_meta;
        if (!primed) begin
            s_next.settle = s_reg.settle + 2'h1;
        end
        // live levels; detect bits freeze while the card is identified
        s_next.cst_stat = s_reg.cst_sync;
        s_next.rdy_stat = s_reg.rdy_sync;
        s_next.pwr_stat = socket_powered;
        if (!interrogation_busy) begin
            s_next.cd_stat = s_reg.cd_sync;                  // R8 R17
        end
        // change detection is held off until the pins are settled,
        // otherwise the reset value would look like a card event
        ev_set = 4'h0;
        ev_set[csms_pkg::FLD_POWER] = primed && (s_next.pwr_stat != s_reg.pwr_stat); // R15
        ev_set[csms_pkg::FLD_CD_HI] = primed && (s_next.cd_stat[1] != s_reg.cd_stat[1]); // R15
        ev_set[csms_pkg::FLD_CD_LO] = primed && (s_next.cd_stat[0] != s_reg.cd_stat[0]); // R15
        if (card_is_cardbus) begin
            ev_set[csms_pkg::FLD_CSTS] = primed && s_next.cst_stat && !s_reg.cst_stat; // R16
        end else begin
            ev_set[csms_pkg::FLD_CSTS] = primed && (s_next.cst_stat != s_reg.cst_stat); // R16
        end
        if (wr_force) begin
            ev_set = ev_set | reg_wdata[3:0];                // R6
        end
        ev_clr = 4'h0;
        if (reg_wr && (reg_addr == csms_pkg::OFS_EVENT)) begin
            ev_clr = reg_wdata[3:0];                         // R15
        end
        // set wins over a simultaneous clear; mask takes no part
        s_next.events = (s_reg.events & ~ev_clr) | ev_set;   // R1
        // mask keeps only its low four bits
        if (reg_wr && (reg_addr == csms_pkg::OFS_MASK)) begin
            s_next.mask = reg_wdata[3:0];                    // R5
        end
        // card voltage bits: probe result at insertion, force overrides
        if (insertion_done) begin
            s_next.card_volt = probed_card_volt;             // R7
        end
        if (wr_force) begin
            s_next.card_volt = reg_wdata[csms_pkg::FLD_VOLT_HI:csms_pkg::FLD_VOLT_LO]; // R6
            s_next.video     = reg_wdata[csms_pkg::FLD_VIDEO]; // R6 R11
        end
        // read mux; force register is write-only and reads zero
        s_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                csms_pkg::OFS_EVENT:  s_next.rdata = {28'h0000000, s_reg.events};
                csms_pkg::OFS_MASK:   s_next.rdata = {28'h0000000, s_reg.mask}; // R5
                csms_pkg::OFS_STATUS: s_next.rdata = status_word;
                default:              s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg           <= '0;                           // R14
            s_reg.mask      <= csms_pkg::MASK_RESET;
            s_reg.events    <= csms_pkg::EVENT_RESET;
            s_reg.cd_stat   <= 2'h3;                         // empty socket until sampled
            // detect stages start at the empty-socket level, so the shown
            // bits never dip to card-present while the pipeline fills
            s_reg.cd_meta   <= 2'h3;
            s_reg.cd_sync   <= 2'h3;
        end else begin
            s_reg <= s_next;
        end
    end

    // both detect flags share the two-bit enable; 01 and 10 act as off
    always_comb begin
        irq_en = {s_reg.mask[3], s_reg.mask[2] & s_reg.mask[1],
                  s_reg.mask[2] & s_reg.mask[1], s_reg.mask[0]}; // R2 R3 R4
    end
    assign status_change_interrupt = |(s_reg.events & irq_en); // R18
    assign reg_rdata = s_reg.rdata;

    property p_mask_upper_zero;
        @(posedge clock) disable iff (rst)
        reg_rd && (reg_addr == csms_pkg::OFS_MASK) |=> (reg_rdata[31:4] == 28'h0000000);
    endproperty
    a_mask_upper_zero: assert property (p_mask_upper_zero) else $error("mask upper bits not zero"); // R5

    property p_status_supply;
        @(posedge clock) disable iff (rst)
        reg_rd && (reg_addr == csms_pkg::OFS_STATUS)
            |=> (reg_rdata[31:28] == 4'h3) && (reg_rdata[26:14] == 13'h0000);
    endproperty
    a_status_supply: assert property (p_status_supply) else $error("fixed status bits wrong"); // R9 R10 R12

    property p_power_irq;
        @(posedge clock) disable iff (rst)
        s_reg.events[3] && s_reg.mask[3] |-> status_change_interrupt;
    endproperty
    a_power_irq: assert property (p_power_irq) else $error("power interrupt missing"); // R2

    property p_csts_irq;
        @(posedge clock) disable iff (rst)
        s_reg.events[0] && s_reg.mask[0] |-> status_change_interrupt;
    endproperty
    a_csts_irq: assert property (p_csts_irq) else $error("status pin interrupt missing"); // R4

    property p_all_masked;
        @(posedge clock) disable iff (rst)
        (s_reg.mask == 4'h0) |-> !status_change_interrupt;
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("interrupt while masked"); // R1 R3

    property p_cd_frozen;
        @(posedge clock) disable iff (rst)
        interrogation_busy |=> $stable(s_reg.cd_stat);
    endproperty
    a_cd_frozen: assert property (p_cd_frozen) else $error("detect bits moved in identification"); // R8

    property p_volt_hold;
        @(posedge clock) disable iff (rst)
        !insertion_done && !wr_force |=> $stable(s_reg.card_volt);
    endproperty
    a_volt_hold: assert property (p_volt_hold) else $error("card voltage bits changed"); // R7

    property p_power_flag;
        @(posedge clock) disable iff (rst)
        primed && (socket_powered != s_reg.pwr_stat) |=> s_reg.events[3];
    endproperty
    a_power_flag: assert property (p_power_flag) else $error("power flag not set"); // R15 R1

    property p_force_volt;
        @(posedge clock) disable iff (rst)
        wr_force |=> (s_reg.card_volt == $past(reg_wdata[13:11]));
    endproperty
    a_force_volt: assert property (p_force_volt) else $error("forced voltage not shown"); // R6

    // detect flags raise the interrupt only through the shared 11 enable
    property p_detect_irq;
        @(posedge clock) disable iff (rst)
        (s_reg.events[2:1] != 2'h0) && (s_reg.mask[2:1] == 2'h3) |-> status_change_interrupt;
    endproperty
    a_detect_irq: assert property (p_detect_irq) else $error("detect interrupt missing"); // R3 R18

    // a falling status pin leaves the flag alone for a cardbus card
    property p_cardbus_fall;
        @(posedge clock) disable iff (rst)
        primed && card_is_cardbus && s_reg.cst_stat && !s_reg.cst_sync
            && !s_reg.events[0] && !wr_force |=> !s_reg.events[0];
    endproperty
    a_cardbus_fall: assert property (p_cardbus_fall) else $error("flag set on falling edge"); // R16

    // outside identification the detect bits track the synchronised pins
    property p_cd_follow;
        @(posedge clock) disable iff (rst)
        !interrogation_busy |=> (s_reg.cd_stat == $past(s_reg.cd_sync));
    endproperty
    a_cd_follow: assert property (p_cd_follow) else $error("detect bits not following pins"); // R17
endmodule
`default_nettype wire

// ==== hdl/csms_pkg.sv ====
// constants for the socket mask and live status register block
// Notes on behaviour
// R1: mask gates interrupt only, flags always set
// R2: mask bit 3 enables power-change interrupt
// R3: mask bits 2-1: 00 off, 11 on
// R4: mask bit 0 enables status-pin interrupt
// R5: mask bits 31-4 read zero, ignore writes
// R6: force writes appear in live status (here only bits 27 and 13-11 do; bits 3-0 set event flags instead)
// R7: card voltage bits change only on insertion (a force write also loads them here)
// R8: detect bits frozen during card identification
// R9: status bits 31,30 read zero
// R10: status bits 29,28 read one
// R11: status bit 27 shows video-port support
// R12: status bits 26-14 read zero
// R13: bits 13-11 show card voltage support
// R14: reset status 3000_00XX, pins follow
// R15: power/detect flags set on change, write-one-clear
// R16: status flag: rising edge cardbus, both 16-bit
// R17: detect bit mirrors pin level, high=empty
// R18: interrupt when any enabled flag set
`default_nettype none
package csms_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_EVENT  = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FORCE  = 8'h0C;
    // field positions
    localparam int FLD_POWER     = 3;
    localparam int FLD_CD_HI     = 2;
    localparam int FLD_CD_LO     = 1;
    localparam int FLD_CSTS      = 0;
    localparam int FLD_READY     = 6;
    localparam int FLD_VOLT_LO   = 11;
    localparam int FLD_VOLT_HI   = 13;
    localparam int FLD_VIDEO     = 27;
    // fixed socket supply bits 31..28: no yy/xx, low and high supported
    localparam logic [3:0] SOCKET_SUPPLY = 4'h3;
    localparam logic [3:0] MASK_RESET    = 4'h0;
    localparam logic [3:0] EVENT_RESET   = 4'h0;
    // cycles after reset before the synchronisers hold real pin levels
    localparam logic [1:0] SETTLE_DONE   = 2'h3;
endpackage
`default_nettype wire

// ==== tb/csms_card_model.sv ====
// behavioural pc card seen from the socket pins
`timescale 1ns/100ps
`default_nettype none
module csms_card_model (
    // card state from the bench
    input  wire logic card_inserted,
    input  wire logic csts_level,
    input  wire logic ready_level,
    // socket pins
    output logic      card_detect_pin_one,
    output logic      card_detect_pin_two,
    output logic      card_status_change_pin,
    output logic      card_ready_pin
);
    // detect pins pulled up while the socket is empty
    assign card_detect_pin_one = ~card_inserted;
    assign card_detect_pin_two = ~card_inserted;
    // status pin pulled down with no card, ready pin pulled up
    assign card_status_change_pin = card_inserted & csts_level;
    assign card_ready_pin = card_inserted ? ready_level : 1'b1;
endmodule
`default_nettype wire

// ==== tb/tb_cardbus_socket_mask_status.sv ====
// self-checking bench for the socket mask and live status registers
`timescale 1ns/100ps
`default_nettype none
module tb_cardbus_socket_mask_status;
    logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic cd1, cd2, csts_pin, rdy_pin, irq;
    logic present = 1'b0, csts = 1'b0, pwr = 1'b0, cbus = 1'b1, busy = 1'b0, ins = 1'b0;
    logic [2:0] volt = 3'h0;
    logic rdy = 1'b1;
    int mismatches = 0, check_count = 0, cycles = 0;
    // clock at 20 MHz
    always #25 clock = ~clock;
    csms_card_model i_card (.card_inserted(present), .csts_level(csts), .ready_level(rdy),
        .card_detect_pin_one(cd1), .card_detect_pin_two(cd2),
        .card_status_change_pin(csts_pin), .card_ready_pin(rdy_pin));
    csms_regs i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .card_detect_pin_one(cd1), .card_detect_pin_two(cd2),
        .card_status_change_pin(csts_pin), .card_ready_pin(rdy_pin),
        .socket_powered(pwr), .card_is_cardbus(cbus), .interrogation_busy(busy),
        .insertion_done(ins), .probed_card_volt(volt), .status_change_interrupt(irq));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, far above the roughly 140 cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one-cycle write strobe, applied on the falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // read data is registered, so it is settled one falling edge later
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        rd_val = reg_rdata;
        reg_rd = 1'b0;
    endtask
    // reads an event flag set, checks irq with mask 0 then mask m, then clears
    task automatic event_case(input string what, input logic [31:0] m);
        idle(6);
        rd(csms_pkg::OFS_EVENT);
        check(what, rd_val, m);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(csms_pkg::OFS_MASK, m);
        check("irq enabled", {31'h0, irq}, 32'h1);
        wr(csms_pkg::OFS_EVENT, m);
        wr(csms_pkg::OFS_MASK, 32'h0);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test %s done", what);
    endtask
    initial begin
        idle(4);
        rst = 1'b0;
        idle(6);
        rd(csms_pkg::OFS_STATUS);
        check("status reset", rd_val, 32'h3000_0046);
        rd(csms_pkg::OFS_MASK);
        check("mask reset", rd_val, 32'h0);
        wr(csms_pkg::OFS_MASK, 32'hFFFF_FFFF);
        rd(csms_pkg::OFS_MASK);
        check("mask bits", rd_val, 32'h0000_000F);
        wr(csms_pkg::OFS_MASK, 32'h0);
        rd(8'h10);
        check("unmapped", rd_val, 32'h0);
        $display("test registers done");
        present = 1'b1;
        event_case("detect flags", 32'h0000_0006);
        rd(csms_pkg::OFS_STATUS);
        check("status inserted", rd_val, 32'h3000_0040);
        rdy = 1'b0;
        idle(4);
        rd(csms_pkg::OFS_STATUS);
        check("ready low", rd_val, 32'h3000_0000);
        rdy = 1'b1;
        pwr = 1'b1;
        event_case("power flag", 32'h0000_0008);
        csts = 1'b1;
        event_case("status rise", 32'h0000_0001);
        csts = 1'b0;
        idle(6);
        rd(csms_pkg::OFS_EVENT);
        check("cardbus fall", rd_val, 32'h0);
        cbus = 1'b0;
        csts = 1'b1;
        event_case("16bit rise", 32'h0000_0001);
        csts = 1'b0;
        event_case("16bit fall", 32'h0000_0001);
        volt = 3'h5;
        ins = 1'b1;
        idle(1);
        ins = 1'b0;
        volt = 3'h2;
        idle(4);
        rd(csms_pkg::OFS_STATUS);
        check("card volt", rd_val, 32'h3000_2848);
        busy = 1'b1;
        present = 1'b0;
        idle(6);
        rd(csms_pkg::OFS_STATUS);
        check("detect frozen", rd_val, 32'h3000_2848);
        busy = 1'b0;
        idle(6);
        rd(csms_pkg::OFS_STATUS);
        check("detect free", rd_val, 32'h3000_284E);
        wr(csms_pkg::OFS_FORCE, 32'h0800_3001);
        rd(csms_pkg::OFS_STATUS);
        check("forced status", rd_val, 32'h3800_304E);
        rd(csms_pkg::OFS_EVENT);
        check("forced flags", rd_val, 32'h0000_0007);
        check("irq still masked", {31'h0, irq}, 32'h0);
        wr(csms_pkg::OFS_MASK, 32'h0000_0006);
        check("detect irq", {31'h0, irq}, 32'h1);
        $display("test status done");
        report_and_stop();
    end
endmodule
`default_nettype wire
